//--- verilog/srrc_defs.vh
`ifndef SRRC_DEFS_VH
`define SRRC_DEFS_VH

`define SRRC_OFF_CTRL    12'h000
`define SRRC_OFF_INSTR   12'h004
`define SRRC_OFF_WREG    12'h008
`define SRRC_OFF_FLAGS   12'h00c
`define SRRC_OFF_BSEL    12'h010
`define SRRC_OFF_SWREG   12'h014
`define SRRC_OFF_SFLAGS  12'h018
`define SRRC_OFF_SBSEL   12'h01c
`define SRRC_OFF_PC      12'h020
`define SRRC_OFF_STACK   12'h024
`define SRRC_OFF_STKPTR  12'h028
`define SRRC_OFF_PCU     12'h02c
`define SRRC_OFF_PCH     12'h030
`define SRRC_OFF_IDXBASE 12'h034
`define SRRC_OFF_MEMADDR 12'h038
`define SRRC_OFF_MEMDATA 12'h03c

`define SRRC_CTRL_EXT    0
`define SRRC_CTRL_BUSY   1
`define SRRC_CTRL_ILL    2
`define SRRC_CTRL_UNF    3

`define SRRC_FLG_C       0
`define SRRC_FLG_Z       2
`define SRRC_FLG_N       4

`define SRRC_RET_PAT     15'h0009
`define SRRC_RLC_PAT     6'h0d
`define SRRC_LIT_MAX     8'h5f
`define SRRC_ACC_HI_BANK 4'hf
`define SRRC_STK_DEPTH   5'h1f
`define SRRC_Q_READ      2'h1
`define SRRC_Q_LAST      2'h3

`endif

//--- verilog/srrc_core.v
`timescale 1ns/1ps
`default_nettype none
`include "srrc_defs.vh"

module srrc_core (
  input  wire        i_clk,
  input  wire        i_rst_n,
  input  wire        i_psel,
  input  wire        i_penable,
  input  wire        i_pwrite,
  input  wire [11:0] i_paddr,
  input  wire [31:0] i_pwdata,
  output reg  [31:0] o_prdata,
  output reg         o_pready,
  output reg         o_pslverr,
  output reg         o_busy
);

  localparam [2:0] ST_IDLE = 3'b001;
  localparam [2:0] ST_EXEC = 3'b010;
  localparam [2:0] ST_NOP  = 3'b100;

  reg  [1:0]  q_r;
  reg  [2:0]  st_r;
  reg         pend_r;
  reg  [15:0] ir_r;
  reg         ext_r;
  reg         ill_r;
  reg         unf_r;
  reg  [7:0]  wreg_r;
  reg  [4:0]  flags_r;
  reg  [3:0]  bsel_r;
  reg  [7:0]  swreg_r;
  reg  [4:0]  sflags_r;
  reg  [3:0]  sbsel_r;
  reg  [20:0] pc_r;
  reg  [4:0]  sp_r;
  reg  [4:0]  pc_upper_latch_r;
  reg  [7:0]  pc_high_latch_r;
  reg  [11:0] idxbase_r;
  reg  [11:0] memaddr_r;
  reg  [7:0]  opnd_r;
  reg  [20:0] stk_r [0:30];
  reg  [7:0]  mem_r [0:4095];
  reg  [31:0] rd_nxt;
  reg         err_nxt;

  // bank and offset resolution for a file operand
  function [11:0] srrc_eff_addr;
    input [7:0]  f;
    input        acc;
    input [3:0]  bsel;
    input        ext;
    input [11:0] base;
    begin
      if (acc) begin
        srrc_eff_addr = {bsel, f};
      end else if (ext && (f <= `SRRC_LIT_MAX)) begin
        srrc_eff_addr = base + {4'h0, f};
      end else if (f <= `SRRC_LIT_MAX) begin
        srrc_eff_addr = {4'h0, f};
      end else begin
        srrc_eff_addr = {`SRRC_ACC_HI_BANK, f};
      end
    end
  endfunction

  wire        is_ret   = (ir_r[15:1] == `SRRC_RET_PAT);
  wire        ret_s    = ir_r[0];
  wire        is_rlc   = (ir_r[15:10] == `SRRC_RLC_PAT);
  wire        rlc_d    = ir_r[9];
  wire        rlc_a    = ir_r[8];
  wire [11:0] eff_addr = srrc_eff_addr(ir_r[7:0], rlc_a, bsel_r, ext_r, idxbase_r);
  wire        q_last   = (q_r == `SRRC_Q_LAST);
  wire        exec_end = st_r[1] && q_last;
  wire [20:0] stk_top  = (sp_r != 5'h00) ? stk_r[sp_r - 5'h01] : 21'h000000;

  wire [7:0] rot_res;
  assign rot_res[0] = flags_r[`SRRC_FLG_C];
  genvar gi;
  generate
    for (gi = 1; gi < 8; gi = gi + 1) begin : g_rot
      assign rot_res[gi] = opnd_r[gi-1];
    end
  endgenerate

  wire setup  = i_psel && !i_penable;
  wire acc_ok = i_psel && i_penable && o_pready && !o_pslverr;
  wire bus_wr = acc_ok && i_pwrite;
  wire busy   = pend_r || !st_r[0];

  // apb read data and refusal, decided in the setup cycle
  always @* begin
    rd_nxt  = 32'h00000000;
    err_nxt = 1'b0;
    case (i_paddr)
      `SRRC_OFF_CTRL:    rd_nxt = {28'h0000000, unf_r, ill_r, busy, ext_r};
      `SRRC_OFF_INSTR:   rd_nxt = {16'h0000, ir_r};
      `SRRC_OFF_WREG:    rd_nxt = {24'h000000, wreg_r};
      `SRRC_OFF_FLAGS:   rd_nxt = {27'h0000000, flags_r};
      `SRRC_OFF_BSEL:    rd_nxt = {28'h0000000, bsel_r};
      `SRRC_OFF_SWREG:   rd_nxt = {24'h000000, swreg_r};
      `SRRC_OFF_SFLAGS:  rd_nxt = {27'h0000000, sflags_r};
      `SRRC_OFF_SBSEL:   rd_nxt = {28'h0000000, sbsel_r};
      `SRRC_OFF_PC:      rd_nxt = {11'h000, pc_r};
      `SRRC_OFF_STACK: begin
        rd_nxt  = {11'h000, stk_top};
        err_nxt = i_pwrite && (sp_r == `SRRC_STK_DEPTH);
      end
      `SRRC_OFF_STKPTR:  rd_nxt = {27'h0000000, sp_r};
      `SRRC_OFF_PCU:     rd_nxt = {27'h0000000, pc_upper_latch_r};
      `SRRC_OFF_PCH:     rd_nxt = {24'h000000, pc_high_latch_r};
      `SRRC_OFF_IDXBASE: rd_nxt = {20'h00000, idxbase_r};
      `SRRC_OFF_MEMADDR: rd_nxt = {20'h00000, memaddr_r};
      `SRRC_OFF_MEMDATA: rd_nxt = {24'h000000, mem_r[memaddr_r]};
      default:           err_nxt = 1'b1;
    endcase
    if (i_pwrite && busy) begin
      err_nxt = 1'b1;
    end
  end

  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_prdata  <= 32'h00000000;
      o_pready  <= 1'b0;
      o_pslverr <= 1'b0;
    end else if (setup) begin
      o_prdata  <= rd_nxt;
      o_pready  <= 1'b1;
      o_pslverr <= err_nxt;
    end else begin
      o_pready  <= 1'b0;
      o_pslverr <= 1'b0;
    end
  end

  // quarter phases of the instruction cycle
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      q_r <= 2'h0;
    end else begin
      q_r <= q_r + 2'h1;
    end
  end

  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_r   <= ST_IDLE;
      pend_r <= 1'b0;
      o_busy <= 1'b0;
      opnd_r <= 8'h00;
    end else begin
      o_busy <= busy;
      if (bus_wr && (i_paddr == `SRRC_OFF_INSTR)) begin
        pend_r <= 1'b1;
      end
      if (st_r[1] && (q_r == `SRRC_Q_READ)) begin
        opnd_r <= mem_r[eff_addr];
      end
      case (st_r)
        ST_IDLE: begin
          if (pend_r && q_last) begin
            pend_r <= 1'b0;
            st_r   <= ST_EXEC;
          end
        end
        ST_EXEC: begin
          if (q_last) begin
            st_r <= is_ret ? ST_NOP : ST_IDLE;
          end
        end
        ST_NOP: begin
          if (q_last) begin
            st_r <= ST_IDLE;
          end
        end
        default: st_r <= ST_IDLE;
      endcase
    end
  end

  // core registers, written by software when idle or by execution
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ir_r             <= 16'h0000;
      ext_r            <= 1'b0;
      ill_r            <= 1'b0;
      unf_r            <= 1'b0;
      wreg_r           <= 8'h00;
      flags_r          <= 5'h00;
      bsel_r           <= 4'h0;
      swreg_r          <= 8'h00;
      sflags_r         <= 5'h00;
      sbsel_r          <= 4'h0;
      pc_r             <= 21'h000000;
      sp_r             <= 5'h00;
      pc_upper_latch_r <= 5'h00;
      pc_high_latch_r  <= 8'h00;
      idxbase_r        <= 12'h000;
      memaddr_r        <= 12'h000;
    end else begin
      if (bus_wr) begin
        case (i_paddr)
          `SRRC_OFF_CTRL: begin
            ext_r <= i_pwdata[`SRRC_CTRL_EXT];
            if (i_pwdata[`SRRC_CTRL_ILL]) begin
              ill_r <= 1'b0;
            end
            if (i_pwdata[`SRRC_CTRL_UNF]) begin
              unf_r <= 1'b0;
            end
          end
          `SRRC_OFF_INSTR:   ir_r <= i_pwdata[15:0];
          `SRRC_OFF_WREG:    wreg_r <= i_pwdata[7:0];
          `SRRC_OFF_FLAGS:   flags_r <= i_pwdata[4:0];
          `SRRC_OFF_BSEL:    bsel_r <= i_pwdata[3:0];
          `SRRC_OFF_SWREG:   swreg_r <= i_pwdata[7:0];
          `SRRC_OFF_SFLAGS:  sflags_r <= i_pwdata[4:0];
          `SRRC_OFF_SBSEL:   sbsel_r <= i_pwdata[3:0];
          `SRRC_OFF_PC:      pc_r <= i_pwdata[20:0];
          `SRRC_OFF_STACK:   sp_r <= sp_r + 5'h01;
          `SRRC_OFF_PCU:     pc_upper_latch_r <= i_pwdata[4:0];
          `SRRC_OFF_PCH:     pc_high_latch_r <= i_pwdata[7:0];
          `SRRC_OFF_IDXBASE: idxbase_r <= i_pwdata[11:0];
          `SRRC_OFF_MEMADDR: memaddr_r <= i_pwdata[11:0];
          default: ;
        endcase
      end
      if (exec_end) begin
        if (is_ret) begin
          pc_r <= stk_top;
          if (sp_r != 5'h00) begin
            sp_r <= sp_r - 5'h01;
          end else begin
            unf_r <= 1'b1;
          end
          // latches always kept; flags kept unless shadows restored
          if (ret_s) begin
            wreg_r  <= swreg_r;
            flags_r <= sflags_r;
            bsel_r  <= sbsel_r;
          end
        end else if (is_rlc) begin
          flags_r[`SRRC_FLG_C] <= opnd_r[7];
          flags_r[`SRRC_FLG_N] <= rot_res[7];
          flags_r[`SRRC_FLG_Z] <= (rot_res == 8'h00);
          if (!rlc_d) begin
            wreg_r <= rot_res;
          end
        end else begin
          ill_r <= 1'b1;
        end
      end
    end
  end

  // data memory, loaded by software or by rotate writeback
  always @(posedge i_clk) begin
    if (bus_wr && (i_paddr == `SRRC_OFF_MEMDATA)) begin
      mem_r[memaddr_r] <= i_pwdata[7:0];
    end else if (exec_end && !is_ret && is_rlc && rlc_d) begin
      mem_r[eff_addr] <= rot_res;
    end
  end

  always @(posedge i_clk) begin
    if (bus_wr && (i_paddr == `SRRC_OFF_STACK) && (sp_r != `SRRC_STK_DEPTH)) begin
      stk_r[sp_r] <= i_pwdata[20:0];
    end
  end

endmodule // srrc_core
`default_nettype wire

//--- testbench/srrc_checker.sv
`timescale 1ns/1ps
`default_nettype none
module srrc_checker (
  input wire        i_clk,
  input wire        i_rst_n,
  input wire        i_psel,
  input wire        i_penable,
  input wire        i_pwrite,
  input wire [11:0] i_paddr,
  input wire [31:0] i_pwdata,
  input wire [31:0] o_prdata,
  input wire        o_pready,
  input wire        o_pslverr,
  input wire        o_busy
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  wire stp = i_psel && !i_penable;
  property p_rdy; stp |=> o_pready; endproperty
  a_rdy: assert property (p_rdy) else $error("ready missing after setup");
  property p_one; o_pready |=> !o_pready; endproperty
  a_one: assert property (p_one) else $error("ready longer than one cycle");
  property p_acc; o_pready |-> i_psel && i_penable; endproperty
  a_acc: assert property (p_acc) else $error("ready outside access phase");
  property p_err; o_pslverr |-> o_pready; endproperty
  a_err: assert property (p_err) else $error("error without ready");
  property p_unm; stp && i_paddr > 12'h03c |=> o_pslverr; endproperty
  a_unm: assert property (p_unm) else $error("unmapped access accepted");
  property p_rdok; stp && !i_pwrite && i_paddr <= 12'h03c && i_paddr[1:0] == 2'h0 |=> !o_pslverr; endproperty
  a_rdok: assert property (p_rdok) else $error("mapped read refused");
  property p_flw; stp && !i_pwrite && i_paddr == 12'h00c |=> o_prdata[31:5] == 27'h0; endproperty
  a_flw: assert property (p_flw) else $error("flags read wider than five bits");
  property p_go; stp && i_pwrite && i_paddr == 12'h004 && !o_busy ##1 !o_pslverr |-> ##[1:3] o_busy; endproperty
  a_go: assert property (p_go) else $error("issued instruction never busy");
  property p_done; $rose(o_busy) |-> ##[1:20] !o_busy; endproperty
  a_done: assert property (p_done) else $error("instruction never completes");
endmodule // srrc_checker
bind srrc_core srrc_checker u_chk (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_psel(i_psel), .i_penable(i_penable),
  .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata), .o_pready(o_pready),
  .o_pslverr(o_pslverr), .o_busy(o_busy));
`default_nettype wire

//--- testbench/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic        i_clk = 1'b0;
  logic        i_rst_n = 1'b0;
  logic        i_psel = 1'b0;
  logic        i_penable = 1'b0;
  logic        i_pwrite = 1'b0;
  logic [11:0] i_paddr = 12'h000;
  logic [31:0] i_pwdata = 32'h0;
  wire  [31:0] o_prdata;
  wire         o_pready;
  wire         o_pslverr;
  wire         o_busy;
  logic [31:0] rdat;
  logic        rerr;
  int          err_total = 0;
  int          n_tests = 0;
  always #2 i_clk = ~i_clk;
  srrc_core u_srrc_core (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_psel(i_psel), .i_penable(i_penable),
    .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata), .o_pready(o_pready),
    .o_pslverr(o_pslverr), .o_busy(o_busy));
  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    n_tests++;
    if (s !== e) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    @(posedge i_clk);
    i_psel <= 1'b1;
    i_pwrite <= w;
    i_paddr <= a;
    i_pwdata <= d;
    @(posedge i_clk);
    i_penable <= 1'b1;
    k = 0;
    do begin
      @(posedge i_clk);
      k++;
    end while (o_pready !== 1'b1 && k < 8);
    rdat = o_prdata;
    rerr = o_pslverr;
    i_psel <= 1'b0;
    i_penable <= 1'b0;
    if (o_pready !== 1'b1) begin
      err_total++;
      end_of_test;
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    chk($sformatf("reg %h", a), e, rdat);
  endtask
  // poll busy until idle
  task automatic wait_idle;
    int k;
    k = 0;
    do begin
      xfer(1'b0, 12'h000, 32'h0);
      k++;
    end while (rdat[1] !== 1'b0 && k < 30);
    if (rdat[1] !== 1'b0) begin
      err_total++;
      end_of_test;
    end
  endtask
  task automatic run(input logic [15:0] op);
    wr(12'h004, 32'(op));
    wait_idle;
  endtask
  task automatic t_ret;
    wr(12'h024, 32'h1234);
    wr(12'h014, 32'ha5);
    wr(12'h018, 32'h13);
    wr(12'h01c, 32'h7);
    wr(12'h008, 32'h11);
    wr(12'h010, 32'h2);
    wr(12'h030, 32'h55);
    wr(12'h02c, 32'h1a);
    run(16'h0013);
    rd(12'h020, 32'h1234);
    rd(12'h028, 32'h0);
    rd(12'h008, 32'ha5);
    rd(12'h00c, 32'h13);
    rd(12'h010, 32'h7);
    rd(12'h030, 32'h55);
    rd(12'h02c, 32'h1a);
    wr(12'h024, 32'h0abc);
    wr(12'h00c, 32'h0a);
    wr(12'h008, 32'h3c);
    wr(12'h010, 32'h5);
    run(16'h0012);
    rd(12'h020, 32'h0abc);
    rd(12'h028, 32'h0);
    rd(12'h008, 32'h3c);
    rd(12'h010, 32'h5);
    rd(12'h00c, 32'h0a);
    rd(12'h030, 32'h55);
    $display("test return done");
  endtask
  task automatic rot(input logic [15:0] op, input logic [11:0] a, input logic [7:0] m, c, w, r, f);
    wr(12'h010, 32'h3);
    wr(12'h038, 32'(a));
    wr(12'h03c, 32'(m));
    wr(12'h00c, 32'(c));
    wr(12'h008, 32'h99);
    run(op);
    rd(12'h008, 32'(w));
    wr(12'h038, 32'(a));
    rd(12'h03c, 32'(r));
    rd(12'h00c, 32'(f));
  endtask
  task automatic t_rot;
    rot(16'h3620, 12'h020, 8'h81, 8'h00, 8'h99, 8'h02, 8'h01);
    rot(16'h3740, 12'h340, 8'h80, 8'h01, 8'h99, 8'h01, 8'h01);
    rot(16'h3470, 12'hf70, 8'h00, 8'h00, 8'h00, 8'h00, 8'h04);
    rot(16'h3540, 12'h340, 8'h40, 8'h00, 8'h80, 8'h40, 8'h10);
    wr(12'h000, 32'h1);
    wr(12'h034, 32'h100);
    rot(16'h3610, 12'h110, 8'h01, 8'h00, 8'h99, 8'h02, 8'h00);
    rot(16'h3660, 12'hf60, 8'hc0, 8'h01, 8'h99, 8'h81, 8'h11);
    wr(12'h000, 32'h0);
    $display("test rotate done");
  endtask
  // illegal opcode, underflow, busy refusal and full stack
  task automatic t_errs;
    int i;
    run(16'hffff);
    rd(12'h000, 32'h4);
    wr(12'h000, 32'hc);
    rd(12'h000, 32'h0);
    wr(12'h008, 32'h5a);
    wr(12'h004, 32'h0012);
    xfer(1'b1, 12'h008, 32'h0);
    chk("busy write error", 32'h1, 32'(rerr));
    wait_idle;
    rd(12'h008, 32'h5a);
    rd(12'h020, 32'h0);
    rd(12'h000, 32'h8);
    wr(12'h000, 32'h8);
    rd(12'h000, 32'h0);
    for (i = 0; i < 31; i++) begin
      wr(12'h024, 32'(i));
    end
    xfer(1'b1, 12'h024, 32'h77);
    chk("full stack error", 32'h1, 32'(rerr));
    rd(12'h028, 32'h1f);
    rd(12'h024, 32'h1e);
    $display("test errors done");
  endtask
  task automatic t_unmapped;
    xfer(1'b0, 12'h040, 32'h0);
    chk("read error", 32'h1, 32'(rerr));
    xfer(1'b1, 12'h044, 32'h5);
    chk("write error", 32'h1, 32'(rerr));
    $display("test unmapped done");
  endtask
  initial begin
    repeat (4) @(posedge i_clk);
    i_rst_n <= 1'b1;
    t_ret();
    t_rot();
    t_errs();
    t_unmapped();
    end_of_test();
  end
endmodule // tb
`default_nettype wire
